// [bench/sesr_host_model.sv]
/*
 * Remote host model: issues decoded common commands, one at a time.
 * Assumes the status block samples commands on the rising edge.
 */
`timescale 1ns/1ps
module sesr_host_model import sesr_pkg::*; (
   input wire logic core_clk_i,
   output logic cmd_valid_o,
   output sesr_cmd_t cmd_code_o,
   output logic [7:0] cmd_arg_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = SESR_CMD_NONE;
      cmd_arg_o = 8'h00;
   end

   // ==========================================================
   // one command per call; an 8-bit argument cannot leave 0..255
   task automatic send(input sesr_cmd_t c, input logic [7:0] a);
      @(posedge core_clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o <= c;
      cmd_arg_o <= a;
      @(posedge core_clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o <= SESR_CMD_NONE;
      cmd_arg_o <= 8'h00;
   endtask
endmodule

// [bench/sesr_top_test.sv]
/*
 * Self-checking bench of the standard event status block.
 * Assumes sesr_pkg and the host model are compiled first.
 */
`timescale 1ns/1ps
module sesr_top_test import sesr_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic busy = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [2:0] cond = 3'h0;
   logic cv;
   sesr_cmd_t cc;
   logic [7:0] ca;
   logic rv, esb, srq, ob;
   logic [7:0] rd, fl, ee, se, sb;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;

   always #2 clk = ~clk;

   sesr_host_model host (.core_clk_i(clk), .cmd_valid_o(cv), .cmd_code_o(cc),
      .cmd_arg_o(ca));

   sesr_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
      .cmd_code_i(cc), .cmd_arg_i(ca), .ops_busy_i(busy), .query_err_i(ev[0]),
      .device_err_i(ev[1]), .exec_err_i(ev[2]), .syntax_err_i(ev[3]),
      .err_queue_i(cond[0]), .ques_summary_i(cond[1]), .msg_avail_i(cond[2]),
      .resp_valid_o(rv), .resp_data_o(rd), .event_flags_o(fl),
      .event_enable_o(ee), .stb_enable_o(se), .status_byte_o(sb),
      .esb_summary_o(esb), .service_req_o(srq), .opc_busy_o(ob));

   // ==========================================================
   // shared helpers
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic cmd(input sesr_cmd_t c, input logic [7:0] a);
      host.send(c, a);
      #1;
   endtask

   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
      #1;
   endtask

   task automatic query(input sesr_cmd_t c, input string n, input logic [7:0] exp);
      cmd(c, 8'h00);
      chk({n, " valid"}, {7'h00, rv}, 8'h01);
      chk(n, rd, exp);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk("flags", fl, 8'h80);
      chk("ese", ee, 8'h00);
      chk("sre", se, 8'h00);
      chk("stb", sb, 8'h00);
   endtask

   task automatic t_events();
      logic [7:0] exp;
      exp = 8'h80;
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         exp = exp | (8'h04 << i);
         chk("flags ev", fl, exp);
      end
      repeat (3) @(posedge clk);
      cmd(SESR_CMD_RST, 8'h00);
      chk("flags held", fl, 8'hBC);
      chk("unused", fl & 8'h42, 8'h00);
      query(SESR_CMD_ESR_Q, "esr", 8'hBC);
      chk("flags clr", fl, 8'h00);
      query(SESR_CMD_ESR_Q, "esr2", 8'h00);
   endtask

   task automatic t_enable();
      cmd(SESR_CMD_ESE, 8'h41);
      chk("ese", ee, 8'h41);
      query(SESR_CMD_ESE_Q, "ese q", 8'h41);
      pulse(4'h8);
      chk("esb off", {7'h00, esb}, 8'h00);
      cmd(SESR_CMD_ESE, 8'h20);
      chk("ese new", ee, 8'h20);
      chk("esb on", {7'h00, esb}, 8'h01);
      chk("stb esb", sb, 8'h20);
      cmd(SESR_CMD_CLS, 8'h00);
      chk("cls flags", fl, 8'h00);
      chk("cls stb", sb, 8'h00);
   endtask

   task automatic t_status();
      cmd(SESR_CMD_SRE, 8'h20);
      chk("sre", se, 8'h20);
      query(SESR_CMD_SRE_Q, "sre q", 8'h20);
      query(SESR_CMD_SRE_Q, "sre q2", 8'h20);
      @(posedge clk);
      cond <= 3'h4;
      pulse(4'h8);
      chk("stb mss", sb, 8'h70);
      chk("srq", {7'h00, srq}, 8'h01);
      query(SESR_CMD_STB_Q, "stb q", 8'h70);
      chk("mss kept", sb, 8'h70);
      query(SESR_CMD_ESR_Q, "esr", 8'h20);
      chk("stb clr", sb, 8'h10);
      @(posedge clk);
      cond <= 3'h0;
   endtask

   task automatic t_opc();
      @(posedge clk);
      busy <= 1'b1;
      cmd(SESR_CMD_OPC, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk("opc wait", {6'h00, ob, fl[0]}, 8'h02);
      @(posedge clk);
      busy <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("opc done", {6'h00, ob, fl[0]}, 8'h01);
      cmd(SESR_CMD_OPC_Q, 8'h00);
      for (int i = 0; i < 10 && rv !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("opc q valid", {7'h00, rv}, 8'h01);
      chk("opc q", rd, 8'h01);
   endtask

   task automatic t_power();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("pwr flags", fl, 8'h80);
      chk("pwr ese", ee, 8'h00);
      chk("pwr sre", se, 8'h00);
      chk("pwr stb", sb, 8'h00);
      cmd(SESR_CMD_OPC, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("opc idle", {6'h00, ob, fl[0]}, 8'h01);
      cmd(SESR_CMD_ESE, 8'h04);
      pulse(4'h1);
      chk("esb qe", {7'h00, esb}, 8'h01);
      chk("stb qe", sb, 8'h20);
      query(SESR_CMD_ESR_Q, "esr pwr", 8'h85);
      chk("esr stb", sb, 8'h00);
   endtask

   // ==========================================================
   // run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_reset();
      t_events();
      t_enable();
      t_status();
      t_opc();
      t_power();
      summarize();
   end
endmodule

// [verilog/sesr_defs.svh]
/*
 * Constants of the standard event status block: bit positions, masks and
 * reset values. Assumes it is included by bare name from the package and
 * from the design modules.
 */
`ifndef SESR_DEFS_SVH
`define SESR_DEFS_SVH

// ==========================================================
// widths
`define SESR_BYTE_W 8

// ==========================================================
// event register bit positions
`define SESR_EV_OPC 0
`define SESR_EV_UNUSED1 1
`define SESR_EV_QUERY 2
`define SESR_EV_DEVICE 3
`define SESR_EV_EXEC 4
`define SESR_EV_CMD 5
`define SESR_EV_UNUSED6 6
`define SESR_EV_PWR 7

// bits that can ever be set
`define SESR_EV_USED_MASK 8'hBD
// power-on flag is up straight out of reset
`define SESR_EV_RST_VAL 8'h80
`define SESR_ESE_RST_VAL 8'h00
`define SESR_SRE_RST_VAL 8'h00

// ==========================================================
// status byte bit positions
`define SESR_STB_ERRQ 2
`define SESR_STB_QUES 3
`define SESR_STB_MAV 4
`define SESR_STB_ESB 5
`define SESR_STB_MSS 6
`define SESR_STB_RST_VAL 8'h00

// value returned by the operation-complete query
`define SESR_OPC_REPLY 8'h01

`endif

// [verilog/sesr_event_bit.sv]
/*
 * One latched event flag with set-over-clear priority. Assumes a single
 * clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module sesr_event_bit #(
   parameter logic RST_VAL = 1'b0,
   parameter logic USED = 1'b1
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic q_o,
   output logic next_o
);
   // a set in the clearing cycle survives; unused bits never leave zero
   assign next_o = USED ? (set_i | (q_o & ~clr_i)) : 1'b0;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_o <= USED ? RST_VAL : 1'b0;
      end else begin
         q_o <= next_o;
      end
   end
endmodule

// [verilog/sesr_masked_or.sv]
/*
 * Masked summary: OR of the bitwise AND of a value and its enable mask.
 * Purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ps
module sesr_masked_or #(
   parameter int W = 8
) (
   input wire logic [W-1:0] val_i,
   input wire logic [W-1:0] mask_i,
   output logic any_o
);
   assign any_o = |(val_i & mask_i);
endmodule

// [verilog/sesr_pkg.sv]
/*
 * Types of the standard event status block: command codes and the
 * operation-complete tracking states. Assumes the defs header is on the
 * include path.
 */
package sesr_pkg;
`include "sesr_defs.svh"

   // ==========================================================
   // commands presented by the command parser
   typedef enum logic [3:0] {
      SESR_CMD_NONE,
      SESR_CMD_CLS,
      SESR_CMD_ESE,
      SESR_CMD_ESE_Q,
      SESR_CMD_ESR_Q,
      SESR_CMD_SRE,
      SESR_CMD_SRE_Q,
      SESR_CMD_STB_Q,
      SESR_CMD_OPC,
      SESR_CMD_OPC_Q,
      SESR_CMD_RST
   } sesr_cmd_t;

   // ==========================================================
   // operation-complete tracking
   typedef enum logic [1:0] {
      SESR_OPC_IDLE,
      SESR_OPC_WAIT_SET,
      SESR_OPC_WAIT_REPLY
   } sesr_opc_state_t;

endpackage

// [verilog/sesr_top.sv]
/*
 * Standard event status register, its enable mask, the status byte and
 * its enable mask, driven by decoded common commands. Assumes the command
 * parser presents one command per cycle, synchronous to core_clk_i, and
 * that event inputs are one-cycle pulses from their sources.
 */
`timescale 1ns/1ps
`include "sesr_defs.svh"
module sesr_top import sesr_pkg::*; #(
   parameter int DATA_W = 8
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire sesr_cmd_t cmd_code_i,
   input wire logic [DATA_W-1:0] cmd_arg_i,
   input wire logic ops_busy_i,
   input wire logic query_err_i,
   input wire logic device_err_i,
   input wire logic exec_err_i,
   input wire logic syntax_err_i,
   input wire logic err_queue_i,
   input wire logic ques_summary_i,
   input wire logic msg_avail_i,
   output logic resp_valid_o,
   output logic [DATA_W-1:0] resp_data_o,
   output logic [DATA_W-1:0] event_flags_o,
   output logic [DATA_W-1:0] event_enable_o,
   output logic [DATA_W-1:0] stb_enable_o,
   output logic [DATA_W-1:0] status_byte_o,
   output logic esb_summary_o,
   output logic service_req_o,
   output logic opc_busy_o
);
   // ==========================================================
   // elaboration check
   if (DATA_W != `SESR_BYTE_W) begin : g_bad_width
      $error("sesr_top: DATA_W must be 8");
   end

   // ==========================================================
   // command decode
   logic do_cls;
   logic do_ese;
   logic do_ese_q;
   logic do_esr_q;
   logic do_sre;
   logic do_sre_q;
   logic do_stb_q;
   logic do_opc;
   logic do_opc_q;
   logic imm_reply;

   assign do_cls = cmd_valid_i && (cmd_code_i == SESR_CMD_CLS);
   assign do_ese = cmd_valid_i && (cmd_code_i == SESR_CMD_ESE);
   assign do_ese_q = cmd_valid_i && (cmd_code_i == SESR_CMD_ESE_Q);
   assign do_esr_q = cmd_valid_i && (cmd_code_i == SESR_CMD_ESR_Q);
   assign do_sre = cmd_valid_i && (cmd_code_i == SESR_CMD_SRE);
   assign do_sre_q = cmd_valid_i && (cmd_code_i == SESR_CMD_SRE_Q);
   assign do_stb_q = cmd_valid_i && (cmd_code_i == SESR_CMD_STB_Q);
   assign do_opc = cmd_valid_i && (cmd_code_i == SESR_CMD_OPC);
   assign do_opc_q = cmd_valid_i && (cmd_code_i == SESR_CMD_OPC_Q);
   assign imm_reply = do_ese_q | do_esr_q | do_sre_q | do_stb_q;

   // ==========================================================
   // operation-complete tracking
   sesr_opc_state_t opc_state;
   sesr_opc_state_t next_opc_state;
   logic opc_set;
   logic opc_reply;

   always_comb begin
      next_opc_state = opc_state;
      opc_set = 1'b0;
      opc_reply = 1'b0;
      case (opc_state)
         SESR_OPC_IDLE: begin
            next_opc_state = SESR_OPC_IDLE;
         end
         SESR_OPC_WAIT_SET: begin
            // the command itself counts as done once taken
            if (!ops_busy_i) begin
               opc_set = 1'b1;
               next_opc_state = SESR_OPC_IDLE;
            end
         end
         SESR_OPC_WAIT_REPLY: begin
            // an immediate query owns the reply slot; defer a cycle
            if (!ops_busy_i && !imm_reply) begin
               opc_reply = 1'b1;
               next_opc_state = SESR_OPC_IDLE;
            end
         end
         default: begin
            next_opc_state = SESR_OPC_IDLE;
         end
      endcase
      // a new request replaces any one still waiting
      if (do_opc) begin
         next_opc_state = SESR_OPC_WAIT_SET;
      end else if (do_opc_q) begin
         next_opc_state = SESR_OPC_WAIT_REPLY;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         opc_state <= SESR_OPC_IDLE;
         opc_busy_o <= 1'b0;
      end else begin
         opc_state <= next_opc_state;
         opc_busy_o <= (next_opc_state != SESR_OPC_IDLE);
      end
   end

   // ==========================================================
   // standard event register
   logic [DATA_W-1:0] ev_set;
   logic [DATA_W-1:0] next_flags;
   localparam logic [DATA_W-1:0] EV_RST_VAL = `SESR_EV_RST_VAL;
   localparam logic [DATA_W-1:0] EV_USED_MASK = `SESR_EV_USED_MASK;
   logic ev_clr;

   assign ev_clr = do_cls | do_esr_q;

   always_comb begin
      ev_set = '0;
      ev_set[`SESR_EV_OPC] = opc_set;
      ev_set[`SESR_EV_QUERY] = query_err_i;
      ev_set[`SESR_EV_DEVICE] = device_err_i;
      ev_set[`SESR_EV_EXEC] = exec_err_i;
      ev_set[`SESR_EV_CMD] = syntax_err_i;
   end

   // power-on bit comes only from the reset value; *RST is not a reset here
   for (genvar i = 0; i < DATA_W; i++) begin : g_ev
      sesr_event_bit #(
         .RST_VAL(EV_RST_VAL[i]),
         .USED(EV_USED_MASK[i])
      ) u_bit (
         .core_clk_i(core_clk_i),
         .rst_n_i(rst_n_i),
         .set_i(ev_set[i]),
         .clr_i(ev_clr),
         .q_o(event_flags_o[i]),
         .next_o(next_flags[i])
      );
   end

   // ==========================================================
   // enable masks
   logic [DATA_W-1:0] next_ese;
   logic [DATA_W-1:0] next_sre;

   assign next_ese = do_ese ? cmd_arg_i : event_enable_o;
   assign next_sre = do_sre ? cmd_arg_i : stb_enable_o;

   // *CLS leaves both masks alone
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         event_enable_o <= `SESR_ESE_RST_VAL;
         stb_enable_o <= `SESR_SRE_RST_VAL;
      end else begin
         event_enable_o <= next_ese;
         stb_enable_o <= next_sre;
      end
   end

   // ==========================================================
   // summaries and status byte
   logic next_esb;
   logic next_mss;
   logic [DATA_W-1:0] stb_low;

   // built from next values so the summary moves with the flag itself
   sesr_masked_or #(.W(DATA_W)) u_esb (
      .val_i(next_flags),
      .mask_i(next_ese),
      .any_o(next_esb)
   );

   always_comb begin
      stb_low = '0;
      stb_low[`SESR_STB_ERRQ] = err_queue_i;
      stb_low[`SESR_STB_QUES] = ques_summary_i;
      stb_low[`SESR_STB_MAV] = msg_avail_i;
      stb_low[`SESR_STB_ESB] = next_esb;
   end

   sesr_masked_or #(.W(DATA_W)) u_mss (
      .val_i(stb_low),
      .mask_i(next_sre),
      .any_o(next_mss)
   );

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_byte_o <= `SESR_STB_RST_VAL;
         esb_summary_o <= 1'b0;
         service_req_o <= 1'b0;
      end else begin
         status_byte_o <= stb_low | ({{(DATA_W - 1){1'b0}}, next_mss} << `SESR_STB_MSS);
         esb_summary_o <= next_esb;
         service_req_o <= next_mss;
      end
   end

   // ==========================================================
   // query replies
   logic [DATA_W-1:0] next_resp;

   always_comb begin
      next_resp = resp_data_o;
      if (do_ese_q) begin
         next_resp = event_enable_o;
      end else if (do_esr_q) begin
         next_resp = event_flags_o;
      end else if (do_sre_q) begin
         next_resp = stb_enable_o;
      end else if (do_stb_q) begin
         // reading does not touch the master summary bit
         next_resp = status_byte_o;
      end else if (opc_reply) begin
         next_resp = `SESR_OPC_REPLY;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         resp_valid_o <= 1'b0;
         resp_data_o <= '0;
      end else begin
         resp_valid_o <= imm_reply | opc_reply;
         resp_data_o <= next_resp;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   logic quiet_events;
   assign quiet_events = !query_err_i && !device_err_i && !exec_err_i && !syntax_err_i;

   sequence opc_taken_s;
      do_opc && !do_opc_q;
   endsequence

   sequence opc_settled_s;
      !ops_busy_i && !do_opc && !do_opc_q;
   endsequence

   opc_sets_bit_a: assert property (opc_taken_s ##1 opc_settled_s |=> event_flags_o[0])
      else $error("operation complete bit not set");

   opc_held_a: assert property (opc_taken_s ##1 (ops_busy_i && !do_opc && !do_opc_q)
      |-> !opc_set)
      else $error("operation complete set while busy");

   unused_bits_a: assert property (!event_flags_o[1] && !event_flags_o[6])
      else $error("unused event bit set");

   query_err_a: assert property (query_err_i |=> event_flags_o[2])
      else $error("query error not latched");

   device_err_a: assert property (device_err_i |=> event_flags_o[3])
      else $error("device error not latched");

   exec_syntax_a: assert property ((exec_err_i |=> event_flags_o[4])
      and (syntax_err_i |=> event_flags_o[5]))
      else $error("execution or command error not latched");

   esb_summary_a: assert property (esb_summary_o == |(event_flags_o & event_enable_o))
      else $error("event summary out of step");

   clear_events_a: assert property ((do_cls || do_esr_q) && quiet_events && !opc_set
      |=> event_flags_o == '0)
      else $error("event register not cleared");

   ese_load_a: assert property (do_ese |=> event_enable_o == $past(cmd_arg_i))
      else $error("event enable not replaced");

   sre_load_a: assert property (do_sre |=> stb_enable_o == $past(cmd_arg_i))
      else $error("status enable not loaded");

   sre_query_a: assert property (do_sre_q && !do_sre
      |=> resp_valid_o && resp_data_o == stb_enable_o && $stable(stb_enable_o))
      else $error("status enable query wrong");

   stb_query_a: assert property (do_stb_q && status_byte_o[6]
      |=> resp_valid_o && resp_data_o[6])
      else $error("status byte query wrong");

   ese_query_a: assert property (do_ese_q && !do_ese
      |=> resp_valid_o && resp_data_o == event_enable_o)
      else $error("event enable query wrong");

   esr_query_a: assert property (do_esr_q
      |=> resp_valid_o && resp_data_o == $past(event_flags_o))
      else $error("event register query wrong");

   latch_hold_a: assert property (!ev_clr |=> (event_flags_o & $past(event_flags_o))
      == $past(event_flags_o))
      else $error("latched event bit dropped");

   esb_cleared_a: assert property (do_cls && quiet_events && !opc_set
      |=> !status_byte_o[5])
      else $error("status byte summary not cleared");

   mss_bit_a: assert property (status_byte_o[6]
      == |(status_byte_o[5:0] & stb_enable_o[5:0]))
      else $error("master summary out of step");

   summary_now_a: assert property (query_err_i && event_enable_o[2] && !do_ese
      |=> esb_summary_o && status_byte_o[5])
      else $error("summary lags the event");
endmodule
